// File: core/irqgt_pkg.sv
// Package of constants and types for the interrupt gating block
package irqgt_pkg;

  // Register byte offsets on APB
  localparam logic [11:0] IRQGT_CTRL_OFF   = 12'h000;
  localparam logic [11:0] IRQGT_EN1_OFF    = 12'h004;
  localparam logic [11:0] IRQGT_EN2_OFF    = 12'h008;
  localparam logic [11:0] IRQGT_PCEN_OFF   = 12'h00c;
  localparam logic [11:0] IRQGT_CFG_OFF    = 12'h010;
  localparam logic [11:0] IRQGT_FLG1_OFF   = 12'h014;
  localparam logic [11:0] IRQGT_FLG2_OFF   = 12'h018;

  // Core control field positions
  localparam int IRQGT_GIE_BIT  = 7;
  localparam int IRQGT_PEN_BIT  = 6;
  localparam int IRQGT_T0E_BIT  = 5;
  localparam int IRQGT_EXE_BIT  = 4;
  localparam int IRQGT_PCE_BIT  = 3;
  localparam int IRQGT_T0F_BIT  = 2;
  localparam int IRQGT_EXF_BIT  = 1;
  localparam int IRQGT_PCF_BIT  = 0;

  // Implemented bit masks of the peripheral registers
  localparam logic [7:0] IRQGT_EN1_MASK = 8'h7f;
  localparam logic [7:0] IRQGT_EN2_MASK = 8'hfd;

  // Reset values
  localparam logic [7:0] IRQGT_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQGT_EN_RST   = 8'h00;
  localparam logic       IRQGT_EDGE_RST = 1'b1;

  // Event inputs from the surrounding sources
  typedef struct packed {
    logic       timer_zero_ovf;
    logic       ext_pin;
    logic [7:0] port_b_pins;
    logic [7:0] periph_one;
    logic [7:0] periph_two;
  } irqgt_events_s;

endpackage

// File: core/irqgt_top.sv
// Interrupt enable and core flag gating block with APB register access
//
// Overview of operation
// - Global enable bit 7 gates every request to the core.
// - Peripheral group enable bit 6 gates all peripheral sources.
// - Enabled peripheral sources request only while group enable is set.
// - Timer zero overflow passes only when bit 5 is set.
// - External pin request passes only when bit 4 is set.
// - Pin change needs bit 3 plus the per-pin change enable.
// - Timer zero overflow flag bit 2 sets on rollover; software clears.
// - External pin flag bit 1 sets on event; only writing 0 clears.
// - Pin change flag bit 0 sets on any change of a pin whose per-pin enable is set; software clears.
// - Unimplemented enable bits read as zero.
// - Enable one bit 6 gates conversion done.
// - Enable one bit 5 gates serial receive.
// - Enable one bit 4 gates serial transmit.
// - Enable one bit 3 gates synchronous serial port.
// - Enable one bit 2 gates first capture compare unit.
// - Enable one bit 1 gates timer two period match.
// - Enable one bit 0 gates timer one overflow.
// - Enable two bit 7 gates oscillator fail.
// - Enable two bits 6 and 5 gate comparators two and one.
// - Enable two bits 4 and 3 gate EEPROM write and bus collision.
// - Enable two bit 2 gates low power wake, bit 0 second capture.
// - Flags set regardless of any enable except the per-pin change enables; clear before enabling.
// - External edge select 1 picks rising, 0 picks falling.
// - Peripheral flags sit bit aligned with enables and are ANDed.
`timescale 1ns/10ps
module irqgt_top
  import irqgt_pkg::*;
(
  // Clock, reset, enable
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // Event sources
  input  wire irqgt_events_s events,
  // Request to the core
  output logic               core_irq_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]    core_irq_control_r;
  logic [7:0]    periph_irq_enable_one_r;
  logic [7:0]    periph_irq_enable_two_r;
  logic [7:0]    per_pin_change_enable_r;
  logic [7:0]    periph_irq_flags_one_r;
  logic [7:0]    periph_irq_flags_two_r;
  logic          ext_edge_select_r;
  irqgt_events_s sync1_r;
  irqgt_events_s sync2_r;
  logic          t0_prev_r;
  logic          ext_prev_r;
  logic [7:0]    pb_prev_r;
  logic          apb_wr;
  logic          t0_evt;
  logic          ext_evt;
  logic          pc_evt;
  logic [7:0]    wdat;
  logic          ctrl_wr;
  logic          periph_req;
  logic          core_req;
  logic [31:0]   rdata_nxt;
  logic          addr_ok;
  logic          setup_phase;
  logic          core_pair_req;
  logic          sel_ctrl;
  logic          sel_en1;
  logic          sel_en2;
  logic          sel_pcen;
  logic          sel_cfg;
  logic          sel_flg1;
  logic          sel_flg2;
  logic [7:0]    pend_one;
  logic [7:0]    pend_two;

  // Write-zero-to-clear flag update: set beats a software clear
  function automatic logic flag_next(input logic cur, input logic wr,
                                     input logic wbit, input logic evt);
    flag_next = evt | (wr ? (cur & wbit) : cur);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser: events come from other logic or pins

  // First stage may go metastable; only the second stage reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
    end else if (clk_en) begin
      sync1_r <= events;
    end
  end

  // Second stage is the only copy that the logic below may read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync2_r <= '0;
    end else if (clk_en) begin
      sync2_r <= sync1_r;
    end
  end

  // Previous level of the rollover line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_prev_r <= 1'b0;
    end else if (clk_en) begin
      t0_prev_r <= sync2_r.timer_zero_ovf;
    end
  end

  // Previous level of the external pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_r <= 1'b0;
    end else if (clk_en) begin
      ext_prev_r <= sync2_r.ext_pin;
    end
  end

  // Previous levels of the port pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_prev_r <= 8'h00;
    end else if (clk_en) begin
      pb_prev_r <= sync2_r.port_b_pins;
    end
  end

  // Previous-level flops reset like the synchroniser, so no edge is
  // seen at release while the inputs idle low
  // Event detection; overflow is a rising edge of the rollover line
  assign t0_evt  = sync2_r.timer_zero_ovf & ~t0_prev_r;
  assign ext_evt = ext_edge_select_r ? (sync2_r.ext_pin & ~ext_prev_r)
                                     : (~sync2_r.ext_pin & ext_prev_r);
  assign pc_evt  = |((sync2_r.port_b_pins ^ pb_prev_r) & per_pin_change_enable_r);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Phase qualifiers; writes land in the access cycle, the pready cycle
  assign setup_phase = psel & ~penable;
  assign apb_wr      = psel & penable & pwrite & clk_en;
  assign wdat        = pwdata[7:0];

  // Register map, one byte each in the low lane of a word:
  //   core control, first and second peripheral enable,
  //   per-pin change enable, configuration (edge select in bit 0),
  //   first and second peripheral flags, in that order from offset 0
  // Upper data lines read as zero and are ignored on writes
  assign sel_ctrl = (paddr == IRQGT_CTRL_OFF);
  assign sel_en1  = (paddr == IRQGT_EN1_OFF);
  assign sel_en2  = (paddr == IRQGT_EN2_OFF);
  assign sel_pcen = (paddr == IRQGT_PCEN_OFF);
  assign sel_cfg  = (paddr == IRQGT_CFG_OFF);
  assign sel_flg1 = (paddr == IRQGT_FLG1_OFF);
  assign sel_flg2 = (paddr == IRQGT_FLG2_OFF);

  // Anything else answers with an error and changes nothing
  assign ctrl_wr = apb_wr & sel_ctrl;
  assign addr_ok = sel_ctrl | sel_en1 | sel_en2 | sel_pcen | sel_cfg | sel_flg1 | sel_flg2;

  ////////////////////////////////////////////////////////////////////////////
  // Core control register: enables plus three sticky flags
  // Bits 7..3 are plain read/write; a write never sets a flag by itself

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_control_r <= IRQGT_CTRL_RST;
    end else if (clk_en) begin
      if (ctrl_wr) begin
        core_irq_control_r[7:3] <= wdat[7:3];
      end
      // Flags set whatever bits 7..3 hold; the pin change flag still needs a per-pin enable
      core_irq_control_r[IRQGT_T0F_BIT] <= flag_next(core_irq_control_r[IRQGT_T0F_BIT],
        ctrl_wr, wdat[IRQGT_T0F_BIT], t0_evt);
      core_irq_control_r[IRQGT_EXF_BIT] <= flag_next(core_irq_control_r[IRQGT_EXF_BIT],
        ctrl_wr, wdat[IRQGT_EXF_BIT], ext_evt);
      // Pin change flag powers up cleared here; its documented value is unknown
      core_irq_control_r[IRQGT_PCF_BIT] <= flag_next(core_irq_control_r[IRQGT_PCF_BIT],
        ctrl_wr, wdat[IRQGT_PCF_BIT], pc_evt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral enables, per-pin enables and edge select

  // First peripheral enable; bit 7 is not implemented and stays 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_enable_one_r <= IRQGT_EN_RST;
    end else if (apb_wr & sel_en1) begin
      periph_irq_enable_one_r <= wdat & IRQGT_EN1_MASK;
    end
  end

  // Second peripheral enable; bit 1 is not implemented and stays 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_enable_two_r <= IRQGT_EN_RST;
    end else if (apb_wr & sel_en2) begin
      periph_irq_enable_two_r <= wdat & IRQGT_EN2_MASK;
    end
  end

  // Per-pin change enables; a pin left at 0 never sets the change flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_pin_change_enable_r <= IRQGT_EN_RST;
    end else if (apb_wr & sel_pcen) begin
      per_pin_change_enable_r <= wdat;
    end
  end

  // Edge select; changing it while the pin moves may drop one event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_edge_select_r <= IRQGT_EDGE_RST;
    end else if (apb_wr & sel_cfg) begin
      ext_edge_select_r <= wdat[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral flags, bit aligned with the enables

  // First flag set: pulses latch; a written 0 clears, a same-cycle set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_flags_one_r <= 8'h00;
    end else if (clk_en) begin
      for (int i = 0; i < 8; i++) begin
        periph_irq_flags_one_r[i] <= IRQGT_EN1_MASK[i] & flag_next(periph_irq_flags_one_r[i],
          apb_wr & sel_flg1, wdat[i], sync2_r.periph_one[i]);
      end
    end
  end

  // Second flag set, same clear rule; the hole at bit 1 stays 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_flags_two_r <= 8'h00;
    end else if (clk_en) begin
      for (int i = 0; i < 8; i++) begin
        periph_irq_flags_two_r[i] <= IRQGT_EN2_MASK[i] & flag_next(periph_irq_flags_two_r[i],
          apb_wr & sel_flg2, wdat[i], sync2_r.periph_two[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request combination

  // Each enable bit ANDs its own flag: bits 6..0 of one, 7..2 and 0 of two
  assign pend_one = periph_irq_enable_one_r &
                    periph_irq_flags_one_r;
  assign pend_two = periph_irq_enable_two_r &
                    periph_irq_flags_two_r;

  // Group enable gates the whole peripheral side in one place
  assign periph_req = core_irq_control_r[IRQGT_PEN_BIT] &
                      ((|pend_one) | (|pend_two));

  // Three core enable/flag pairs, each needing its own enable
  assign core_pair_req =
    (core_irq_control_r[IRQGT_T0E_BIT] & core_irq_control_r[IRQGT_T0F_BIT]) |
    (core_irq_control_r[IRQGT_EXE_BIT] & core_irq_control_r[IRQGT_EXF_BIT]) |
    (core_irq_control_r[IRQGT_PCE_BIT] & core_irq_control_r[IRQGT_PCF_BIT]);

  // Global enable is the last gate, so clearing it silences every source
  assign core_req = core_irq_control_r[IRQGT_GIE_BIT] &
                    (core_pair_req | periph_req);

  // Registered so the core sees a clean level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_req <= 1'b0;
    end else if (clk_en) begin
      core_irq_req <= core_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  // Unmapped reads fall to zero; the error flag tells software why

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      IRQGT_CTRL_OFF: rdata_nxt[7:0] = core_irq_control_r;
      IRQGT_EN1_OFF:  rdata_nxt[7:0] = periph_irq_enable_one_r;
      IRQGT_EN2_OFF:  rdata_nxt[7:0] = periph_irq_enable_two_r;
      IRQGT_PCEN_OFF: rdata_nxt[7:0] = per_pin_change_enable_r;
      IRQGT_CFG_OFF:  rdata_nxt[0]   = ext_edge_select_r;
      IRQGT_FLG1_OFF: rdata_nxt[7:0] = periph_irq_flags_one_r;
      IRQGT_FLG2_OFF: rdata_nxt[7:0] = periph_irq_flags_two_r;
      default:        rdata_nxt = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: no wait state; pready comes from a flop set by the setup cycle

  // Ready answers every setup cycle seen with clk_en high one edge later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= setup_phase;
    end
  end

  // Error goes with pready for an address outside the map
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= setup_phase & ~addr_ok;
    end
  end

  // Read data stands only in the pready cycle; zero otherwise keeps the bus quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      prdata <= (setup_phase & ~pwrite) ? rdata_nxt : 32'h0000_0000;
    end
  end

endmodule // irqgt_top

// File: verification/irqgt_core_model.sv
// Core side model that latches any request it is offered outside an ack cycle
`timescale 1ns/10ps
module irqgt_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic core_irq_req,
  input wire logic ack,
  output logic     seen
);
  // Sticky so a one cycle request is not missed between polls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen <= 1'b0;
    else if (ack) seen <= 1'b0;
    else if (core_irq_req) seen <= 1'b1;
  end
endmodule // irqgt_core_model

// File: verification/irqgt_top_asserts.sv
// Checker of the register port and request gating
`timescale 1ns/10ps
module irqgt_top_asserts
  import irqgt_pkg::*;
(
  // Clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          clk_en,
  // APB
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic [31:0]   prdata,
  input wire logic          pslverr,
  // Events and request
  input wire irqgt_events_s events,
  input wire logic          core_irq_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Transfer phases, each used by one property below
  sequence setup_s;
    psel && !penable && clk_en;
  endsequence
  sequence gie_off_wr_s;
    psel && penable && pready && pwrite && clk_en && paddr == IRQGT_CTRL_OFF &&
    !pwdata[IRQGT_GIE_BIT];
  endsequence
  ready_next_a: assert property (setup_s |=> pready) else $error("no answer after setup");
  ready_pulse_a: assert property (pready && clk_en |=> !pready) else $error("pready held");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper byte set");
  resv_zero_a: assert property (pready && !pwrite |->
    !(paddr == IRQGT_EN1_OFF && prdata[7]) && !(paddr == IRQGT_EN2_OFF && prdata[1]))
    else $error("reserved bit read as one");
  unmapped_err_a: assert property (pready && paddr > IRQGT_FLG2_OFF |-> pslverr)
    else $error("unmapped access without error");
  gie_off_quiet_a: assert property (gie_off_wr_s |-> ##2 !core_irq_req)
    else $error("request with global enable clear");
endmodule // irqgt_top_asserts

bind irqgt_top irqgt_top_asserts irqgt_top_asserts_inst (.pclk, .presetn, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .events, .core_irq_req);

// File: verification/irqgt_top_tb.sv
// Testbench of the interrupt gating block
`timescale 1ns/10ps
module irqgt_top_tb
  import irqgt_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, ack = 1'b0, seen, err;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, core_irq_req;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0, prdata, rd;
  irqgt_events_s ev = '0;
  int            n_fail = 0, tests_run = 0, cyc = 0;
  ////////////////////////////////////////
  always #2.5 pclk = ~pclk;
  irqgt_top irqgt_top_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .events(ev), .core_irq_req);
  irqgt_core_model irqgt_core_model_inst (.pclk, .presetn, .core_irq_req, .ack, .seen);
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  // One APB transfer; an idle edge follows so psel is never driven twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input string s, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(s, {24'h0, e}, rd);
  endtask
  // Clear the core's latch after the request settles, then watch it
  task automatic req_is(input logic e);
    repeat (3) @(posedge pclk);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("request", {31'h0, e}, {31'h0, seen});
  endtask
  task automatic t_regs;
    rchk("ctrl", IRQGT_CTRL_OFF, 8'h00);
    chk("mapped err", 32'h0, {31'h0, err});
    rchk("en1", IRQGT_EN1_OFF, 8'h00);
    rchk("en2", IRQGT_EN2_OFF, 8'h00);
    rchk("unmapped", 12'h01c, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, IRQGT_EN1_OFF, 8'hff);
    rchk("en1 mask", IRQGT_EN1_OFF, 8'h7f);
    apb(1'b1, IRQGT_EN2_OFF, 8'hff);
    rchk("en2 mask", IRQGT_EN2_OFF, 8'hfd);
    apb(1'b1, IRQGT_EN1_OFF, 8'h00);
    apb(1'b1, IRQGT_EN2_OFF, 8'h00);
  endtask
  task automatic t_core;
    ev.timer_zero_ovf <= 1'b1;
    repeat (5) @(posedge pclk);
    ev.timer_zero_ovf <= 1'b0;
    rchk("t0 flag", IRQGT_CTRL_OFF, 8'h04);
    apb(1'b1, IRQGT_CTRL_OFF, 8'ha4);
    req_is(1'b1);
    apb(1'b1, IRQGT_CTRL_OFF, 8'h24);
    req_is(1'b0);
    apb(1'b1, IRQGT_CTRL_OFF, 8'h84);
    req_is(1'b0);
    apb(1'b1, IRQGT_CTRL_OFF, 8'h00);
    apb(1'b1, IRQGT_CFG_OFF, 8'h00);
    ev.ext_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    rchk("rise ignored", IRQGT_CTRL_OFF, 8'h00);
    ev.ext_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    rchk("ext flag", IRQGT_CTRL_OFF, 8'h02);
    apb(1'b1, IRQGT_CTRL_OFF, 8'h92);
    req_is(1'b1);
    apb(1'b1, IRQGT_CTRL_OFF, 8'h82);
    req_is(1'b0);
    apb(1'b1, IRQGT_PCEN_OFF, 8'h01);
    ev.port_b_pins <= 8'h02;
    repeat (5) @(posedge pclk);
    rchk("pin masked", IRQGT_CTRL_OFF, 8'h82);
    ev.port_b_pins <= 8'h03;
    repeat (5) @(posedge pclk);
    rchk("pin flag", IRQGT_CTRL_OFF, 8'h83);
    apb(1'b1, IRQGT_CTRL_OFF, 8'h89);
    req_is(1'b1);
    apb(1'b1, IRQGT_CTRL_OFF, 8'h00);
    rchk("flags clear", IRQGT_CTRL_OFF, 8'h00);
  endtask
  // Every implemented peripheral source in turn, group enable off then on
  task automatic t_periph;
    logic [7:0]  b;
    logic [11:0] en;
    for (int i = 0; i < 16; i++) begin
      b = 8'h01 << i[2:0];
      en = (i < 8) ? IRQGT_EN1_OFF : IRQGT_EN2_OFF;
      if (((i < 8) ? IRQGT_EN1_MASK : IRQGT_EN2_MASK) & b) begin
        if (i < 8) ev.periph_one <= b;
        else ev.periph_two <= b;
        @(posedge pclk);
        ev.periph_one <= 8'h00;
        ev.periph_two <= 8'h00;
        apb(1'b1, en, b);
        apb(1'b1, IRQGT_CTRL_OFF, 8'h80);
        req_is(1'b0);
        apb(1'b1, IRQGT_CTRL_OFF, 8'hc0);
        req_is(1'b1);
        rchk("pflag", en + 12'h010, b);
        apb(1'b1, en + 12'h010, 8'h00);
        apb(1'b1, en, 8'h00);
        apb(1'b1, IRQGT_CTRL_OFF, 8'h00);
      end
    end
  endtask
  // Clock enable low: an event pulse must leave no flag behind
  task automatic t_freeze;
    clk_en <= 1'b0;
    ev.periph_one <= 8'h01;
    repeat (5) @(posedge pclk);
    ev.periph_one <= 8'h00;
    repeat (5) @(posedge pclk);
    clk_en <= 1'b1;
    @(posedge pclk);
    rchk("frozen flag", IRQGT_FLG1_OFF, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, far beyond the under one thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_core;
    t_periph;
    t_freeze;
    tally_and_finish;
  end
endmodule // irqgt_top_tb
